// ==== rtl/ppm_pkg.sv ====
// Purpose: Constants for the port pin alternate function mux
// Assumes: Pin indices within each port as printed
// Notes:   Shared by the mux top module
package ppm_pkg;
   // Port widths
   localparam int P0_W = 7;
   localparam int P3_W = 10;
   localparam int P4_W = 3;
   // Port 0 pin positions
   localparam int P0_TOH_A = 0;
   localparam int P0_TOH_B = 1;
   localparam int P0_NMI   = 2;
   localparam int P0_IRQ0  = 3;
   // Port 3 pin positions
   localparam int P3_TX    = 0;
   localparam int P3_RX    = 1;
   localparam int P3_BAUD  = 2;
   localparam int P3_TMA   = 3;
   localparam int P3_TMB   = 4;
   localparam int P3_TM1   = 5;
   localparam int P3_SDA   = 8;
   localparam int P3_SCL   = 9;
   // Port 4 pin positions
   localparam int P4_SI    = 0;
   localparam int P4_SO    = 1;
   localparam int P4_SCK   = 2;
   // Reset values
   localparam logic [P0_W-1:0] P0_RST = 7'h00;
   localparam logic [P3_W-1:0] P3_RST = 10'h000;
   localparam logic [P4_W-1:0] P4_RST = 3'h0;
   // Input synchroniser reset value
   localparam logic [1:0] SYNC_RST = 2'h0;
endpackage : ppm_pkg

// ==== rtl/ppm_port_pin_mux.sv ====
// Purpose: Per-pin routing between port I/O and peripheral functions
// Assumes: Register bits arrive as plain ports; pins split into in/out/oe
// Notes:   All outputs registered; pin inputs pass three flip-flops, two synchroniser stages and the output register
//
// Summary of operation
// - Standby modes or bus hold force every pin output buffer off.
// - Function enable on port 0 pins 0 and 1 drives the hires timer outputs, ignoring latch and direction.
// - Function enable on port 0 pins 2 to 6 feeds the NMI and external irq inputs 0 to 3 regardless of direction.
// - Function enable on port 3 pins 0, 1, 2 selects serial 0 transmit, receive and baud clock.
// - Port 3 pin 3 picks capture in, compare out, alt timer in or alt timer out from select and ext select.
// - Port 3 pin 4 is capture in with ext select 0, else alt timer in or out per select.
// - Port 3 pin 5 is timer capture in with select 0 and compare out with select 1.
// - Function enable on port 4 pins 0, 1, 2 selects csi0 data in, data out and serial clock.
// - Port 4 pins 1 and 2 work with either open drain setting in csi mode.
// - Function enable 0 gives port operation and 1 the alternate function.
`timescale 1ns/1ps
`default_nettype none
module ppm_port_pin_mux (
   // Clock and reset
   input  wire logic                      core_clk_i,
   input  wire logic                      rst_i,
   // Power and bus state
   input  wire logic                      idle_mode_i,
   input  wire logic                      stop_mode_i,
   input  wire logic                      bus_hold_i,
   // Port 0 register bits
   input  wire logic [ppm_pkg::P0_W-1:0]  p0_latch_i,
   input  wire logic [ppm_pkg::P0_W-1:0]  p0_pin_direction_bit_i,
   input  wire logic [ppm_pkg::P0_W-1:0]  p0_pin_function_enable_bit_i,
   input  wire logic [ppm_pkg::P0_W-1:0]  p0_pin_pullup_enable_bit_i,
   // Port 3 register bits
   input  wire logic [ppm_pkg::P3_W-1:0]  p3_latch_i,
   input  wire logic [ppm_pkg::P3_W-1:0]  p3_pin_direction_bit_i,
   input  wire logic [ppm_pkg::P3_W-1:0]  p3_pin_function_enable_bit_i,
   input  wire logic [ppm_pkg::P3_W-1:0]  p3_pin_function_select_bit_i,
   input  wire logic [ppm_pkg::P3_W-1:0]  p3_pin_function_select_ext_bit_i,
   input  wire logic [ppm_pkg::P3_W-1:0]  p3_pin_open_drain_bit_i,
   input  wire logic [ppm_pkg::P3_W-1:0]  p3_pin_pullup_enable_bit_i,
   // Port 4 register bits
   input  wire logic [ppm_pkg::P4_W-1:0]  p4_latch_i,
   input  wire logic [ppm_pkg::P4_W-1:0]  p4_pin_direction_bit_i,
   input  wire logic [ppm_pkg::P4_W-1:0]  p4_pin_function_enable_bit_i,
   input  wire logic [ppm_pkg::P4_W-1:0]  p4_pin_open_drain_bit_i,
   input  wire logic [ppm_pkg::P4_W-1:0]  p4_pin_pullup_enable_bit_i,
   // Peripheral outputs toward pins
   input  wire logic                      hires_timer_out_a_i,
   input  wire logic                      hires_timer_out_b_i,
   input  wire logic                      serial0_tx_out_i,
   input  wire logic                      timer0_compare_out_a_i,
   input  wire logic                      alt_timer_out_a_i,
   input  wire logic                      alt_timer_out_b_i,
   input  wire logic                      timer1_compare_out_i,
   input  wire logic                      two_wire_data_line_out_i,
   input  wire logic                      two_wire_clock_line_out_i,
   input  wire logic                      csi0_data_out_i,
   input  wire logic                      csi0_serial_clock_out_i,
   input  wire logic                      csi0_serial_clock_oe_i,
   // Pin levels
   input  wire logic [ppm_pkg::P0_W-1:0]  p0_pin_i,
   input  wire logic [ppm_pkg::P3_W-1:0]  p3_pin_i,
   input  wire logic [ppm_pkg::P4_W-1:0]  p4_pin_i,
   // Pin drive
   output var  logic [ppm_pkg::P0_W-1:0]  p0_pin_o,
   output var  logic [ppm_pkg::P0_W-1:0]  p0_pin_oe_o,
   output var  logic [ppm_pkg::P0_W-1:0]  p0_pullup_o,
   output var  logic [ppm_pkg::P3_W-1:0]  p3_pin_o,
   output var  logic [ppm_pkg::P3_W-1:0]  p3_pin_oe_o,
   output var  logic [ppm_pkg::P3_W-1:0]  p3_pullup_o,
   output var  logic [ppm_pkg::P4_W-1:0]  p4_pin_o,
   output var  logic [ppm_pkg::P4_W-1:0]  p4_pin_oe_o,
   output var  logic [ppm_pkg::P4_W-1:0]  p4_pullup_o,
   // Port read values
   output var  logic [ppm_pkg::P0_W-1:0]  p0_read_o,
   output var  logic [ppm_pkg::P3_W-1:0]  p3_read_o,
   output var  logic [ppm_pkg::P4_W-1:0]  p4_read_o,
   // Peripheral inputs from pins
   output var  logic                      nmi_in_o,
   output var  logic [3:0]                ext_irq_in_o,
   output var  logic                      serial0_rx_in_o,
   output var  logic                      serial0_baud_clk_in_o,
   output var  logic                      timer0_capture_in_a_o,
   output var  logic                      alt_timer_in_a_o,
   output var  logic                      timer0_capture_in_b_o,
   output var  logic                      alt_timer_in_b_o,
   output var  logic                      timer1_capture_in_o,
   output var  logic                      two_wire_data_line_in_o,
   output var  logic                      two_wire_clock_line_in_o,
   output var  logic                      csi0_data_in_o,
   output var  logic                      csi0_serial_clock_in_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [ppm_pkg::P0_W-1:0] p0_s1_reg, p0_s2_reg;
   logic [ppm_pkg::P3_W-1:0] p3_s1_reg, p3_s2_reg;
   logic [ppm_pkg::P4_W-1:0] p4_s1_reg, p4_s2_reg;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         p0_s1_reg <= ppm_pkg::P0_RST;
         p0_s2_reg <= ppm_pkg::P0_RST;
         p3_s1_reg <= ppm_pkg::P3_RST;
         p3_s2_reg <= ppm_pkg::P3_RST;
         p4_s1_reg <= ppm_pkg::P4_RST;
         p4_s2_reg <= ppm_pkg::P4_RST;
      end else begin
         p0_s1_reg <= p0_pin_i;
         p0_s2_reg <= p0_s1_reg;
         p3_s1_reg <= p3_pin_i;
         p3_s2_reg <= p3_s1_reg;
         p4_s1_reg <= p4_pin_i;
         p4_s2_reg <= p4_s1_reg;
      end
   end

   // Buffer-off request is a same-clock level
   logic buf_off;
   assign buf_off = idle_mode_i | stop_mode_i | bus_hold_i;

   ////////////////////////////////////////////////////////////////////////////
   // Output and enable selection
   logic [ppm_pkg::P0_W-1:0] p0_out_next, p0_oe_next;
   logic [ppm_pkg::P3_W-1:0] p3_out_next, p3_oe_next;
   logic [ppm_pkg::P4_W-1:0] p4_out_next, p4_oe_next;
   logic                     ts_a, te_a, ts_b, te_b;

   always_comb begin
      ts_a = p3_pin_function_select_bit_i[ppm_pkg::P3_TMA];
      te_a = p3_pin_function_select_ext_bit_i[ppm_pkg::P3_TMA];
      ts_b = p3_pin_function_select_bit_i[ppm_pkg::P3_TMB];
      te_b = p3_pin_function_select_ext_bit_i[ppm_pkg::P3_TMB];
      // Port mode defaults
      p0_out_next = p0_latch_i;
      p0_oe_next  = ~p0_pin_direction_bit_i & ~p0_pin_function_enable_bit_i;
      p3_out_next = p3_latch_i;
      p3_oe_next  = ~p3_pin_direction_bit_i & ~p3_pin_function_enable_bit_i;
      p4_out_next = p4_latch_i;
      p4_oe_next  = ~p4_pin_direction_bit_i & ~p4_pin_function_enable_bit_i;
      // Open drain in port mode: drive only the low level
      p3_oe_next = p3_oe_next & ~(p3_pin_open_drain_bit_i & p3_latch_i);
      p4_oe_next = p4_oe_next & ~(p4_pin_open_drain_bit_i & p4_latch_i);
      // Port 0 timer outputs; input-only functions leave the pin undriven
      if (p0_pin_function_enable_bit_i[ppm_pkg::P0_TOH_A]) begin
         p0_out_next[ppm_pkg::P0_TOH_A] = hires_timer_out_a_i;
         p0_oe_next[ppm_pkg::P0_TOH_A]  = 1'b1;
      end
      if (p0_pin_function_enable_bit_i[ppm_pkg::P0_TOH_B]) begin
         p0_out_next[ppm_pkg::P0_TOH_B] = hires_timer_out_b_i;
         p0_oe_next[ppm_pkg::P0_TOH_B]  = 1'b1;
      end
      // Port 3 serial and timers
      if (p3_pin_function_enable_bit_i[ppm_pkg::P3_TX]) begin
         p3_out_next[ppm_pkg::P3_TX] = serial0_tx_out_i;
         p3_oe_next[ppm_pkg::P3_TX]  = 1'b1;
      end
      if (p3_pin_function_enable_bit_i[ppm_pkg::P3_TMA]) begin
         p3_out_next[ppm_pkg::P3_TMA] = te_a ? alt_timer_out_a_i : timer0_compare_out_a_i;
         p3_oe_next[ppm_pkg::P3_TMA]  = ts_a;
      end
      if (p3_pin_function_enable_bit_i[ppm_pkg::P3_TMB]) begin
         p3_out_next[ppm_pkg::P3_TMB] = alt_timer_out_b_i;
         p3_oe_next[ppm_pkg::P3_TMB]  = te_b & ts_b;
      end
      if (p3_pin_function_enable_bit_i[ppm_pkg::P3_TM1]) begin
         p3_out_next[ppm_pkg::P3_TM1] = timer1_compare_out_i;
         p3_oe_next[ppm_pkg::P3_TM1]  = p3_pin_function_select_bit_i[ppm_pkg::P3_TM1];
      end
      // Two-wire lines are open drain: drive low only, when the line output is low or the latch is clear
      if (p3_pin_function_enable_bit_i[ppm_pkg::P3_SDA]) begin
         p3_out_next[ppm_pkg::P3_SDA] = 1'b0;
         p3_oe_next[ppm_pkg::P3_SDA]  = ~two_wire_data_line_out_i
                                        | ~p3_latch_i[ppm_pkg::P3_SDA];
      end
      if (p3_pin_function_enable_bit_i[ppm_pkg::P3_SCL]) begin
         p3_out_next[ppm_pkg::P3_SCL] = 1'b0;
         p3_oe_next[ppm_pkg::P3_SCL]  = ~two_wire_clock_line_out_i
                                        | ~p3_latch_i[ppm_pkg::P3_SCL];
      end
      // Port 4 clocked serial, push-pull whatever the open drain bits hold
      if (p4_pin_function_enable_bit_i[ppm_pkg::P4_SO]) begin
         p4_out_next[ppm_pkg::P4_SO] = csi0_data_out_i;
         p4_oe_next[ppm_pkg::P4_SO]  = 1'b1;
      end
      if (p4_pin_function_enable_bit_i[ppm_pkg::P4_SCK]) begin
         p4_out_next[ppm_pkg::P4_SCK] = csi0_serial_clock_out_i;
         p4_oe_next[ppm_pkg::P4_SCK]  = csi0_serial_clock_oe_i;
      end
      // Standby or bus hold overrides every output enable
      if (buf_off) begin
         p0_oe_next = ppm_pkg::P0_RST;
         p3_oe_next = ppm_pkg::P3_RST;
         p4_oe_next = ppm_pkg::P4_RST;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered pin drive and pull-ups
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         p0_pin_o    <= ppm_pkg::P0_RST;
         p0_pin_oe_o <= ppm_pkg::P0_RST;
         p0_pullup_o <= ppm_pkg::P0_RST;
         p3_pin_o    <= ppm_pkg::P3_RST;
         p3_pin_oe_o <= ppm_pkg::P3_RST;
         p3_pullup_o <= ppm_pkg::P3_RST;
         p4_pin_o    <= ppm_pkg::P4_RST;
         p4_pin_oe_o <= ppm_pkg::P4_RST;
         p4_pullup_o <= ppm_pkg::P4_RST;
      end else begin
         p0_pin_o    <= p0_out_next;
         p0_pin_oe_o <= p0_oe_next;
         p0_pullup_o <= p0_pin_pullup_enable_bit_i & ~p0_oe_next;
         p3_pin_o    <= p3_out_next;
         p3_pin_oe_o <= p3_oe_next;
         p3_pullup_o <= p3_pin_pullup_enable_bit_i & ~p3_oe_next
                        & ~(p3_pin_function_enable_bit_i & p3_pin_open_drain_bit_i);
         p4_pin_o    <= p4_out_next;
         p4_pin_oe_o <= p4_oe_next;
         p4_pullup_o <= p4_pin_pullup_enable_bit_i & ~p4_oe_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port read path
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         p0_read_o <= ppm_pkg::P0_RST;
         p3_read_o <= ppm_pkg::P3_RST;
         p4_read_o <= ppm_pkg::P4_RST;
      end else begin
         p0_read_o <= (p0_pin_direction_bit_i & p0_s2_reg)
                      | (~p0_pin_direction_bit_i & p0_latch_i);
         p3_read_o <= (p3_pin_direction_bit_i & p3_s2_reg)
                      | (~p3_pin_direction_bit_i & p3_latch_i);
         p4_read_o <= (p4_pin_direction_bit_i & p4_s2_reg)
                      | (~p4_pin_direction_bit_i & p4_latch_i);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Peripheral inputs, gated low when the function is not selected, except the two-wire line inputs
   logic [ppm_pkg::P3_W-1:0] f3;
   assign f3 = p3_pin_function_enable_bit_i;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         nmi_in_o                 <= 1'b0;
         ext_irq_in_o             <= 4'h0;
         serial0_rx_in_o          <= 1'b0;
         serial0_baud_clk_in_o    <= 1'b0;
         timer0_capture_in_a_o    <= 1'b0;
         alt_timer_in_a_o         <= 1'b0;
         timer0_capture_in_b_o    <= 1'b0;
         alt_timer_in_b_o         <= 1'b0;
         timer1_capture_in_o      <= 1'b0;
         two_wire_data_line_in_o  <= 1'b0;
         two_wire_clock_line_in_o <= 1'b0;
         csi0_data_in_o           <= 1'b0;
         csi0_serial_clock_in_o   <= 1'b0;
      end else begin
         nmi_in_o <= p0_pin_function_enable_bit_i[ppm_pkg::P0_NMI]
                     & p0_s2_reg[ppm_pkg::P0_NMI];
         ext_irq_in_o <= p0_pin_function_enable_bit_i[ppm_pkg::P0_W-1:ppm_pkg::P0_IRQ0]
                         & p0_s2_reg[ppm_pkg::P0_W-1:ppm_pkg::P0_IRQ0];
         serial0_rx_in_o <= f3[ppm_pkg::P3_RX] & p3_s2_reg[ppm_pkg::P3_RX];
         serial0_baud_clk_in_o <= f3[ppm_pkg::P3_BAUD] & p3_s2_reg[ppm_pkg::P3_BAUD];
         timer0_capture_in_a_o <= f3[ppm_pkg::P3_TMA] & ~ts_a & ~te_a
                                  & p3_s2_reg[ppm_pkg::P3_TMA];
         alt_timer_in_a_o <= f3[ppm_pkg::P3_TMA] & ~ts_a & te_a
                             & p3_s2_reg[ppm_pkg::P3_TMA];
         timer0_capture_in_b_o <= f3[ppm_pkg::P3_TMB] & ~te_b
                                  & p3_s2_reg[ppm_pkg::P3_TMB];
         alt_timer_in_b_o <= f3[ppm_pkg::P3_TMB] & te_b & ~ts_b
                             & p3_s2_reg[ppm_pkg::P3_TMB];
         timer1_capture_in_o <= f3[ppm_pkg::P3_TM1]
                                & ~p3_pin_function_select_bit_i[ppm_pkg::P3_TM1]
                                & p3_s2_reg[ppm_pkg::P3_TM1];
         two_wire_data_line_in_o <= p3_s2_reg[ppm_pkg::P3_SDA];
         two_wire_clock_line_in_o <= p3_s2_reg[ppm_pkg::P3_SCL];
         csi0_data_in_o <= p4_pin_function_enable_bit_i[ppm_pkg::P4_SI]
                           & p4_s2_reg[ppm_pkg::P4_SI];
         csi0_serial_clock_in_o <= p4_pin_function_enable_bit_i[ppm_pkg::P4_SCK]
                                   & p4_s2_reg[ppm_pkg::P4_SCK];
      end
   end

endmodule : ppm_port_pin_mux
`default_nettype wire

// ==== verification/ppm_port_pin_mux_chk.sv ====
// Purpose: Port-level checks on the pin mux
// Assumes: Single clock domain, async active-high reset
// Notes:   Checks start six cycles after reset release
`timescale 1ns/1ps
`default_nettype none
module ppm_port_pin_mux_chk (
   // Clock and reset
   input  wire logic                      core_clk_i,
   input  wire logic                      rst_i,
   // Controls
   input  wire logic                      idle_mode_i,
   input  wire logic                      stop_mode_i,
   input  wire logic                      bus_hold_i,
   input  wire logic [ppm_pkg::P0_W-1:0]  p0_latch_i,
   input  wire logic [ppm_pkg::P0_W-1:0]  p0_pin_direction_bit_i,
   input  wire logic [ppm_pkg::P0_W-1:0]  p0_pin_function_enable_bit_i,
   input  wire logic [ppm_pkg::P0_W-1:0]  p0_pin_pullup_enable_bit_i,
   input  wire logic [ppm_pkg::P3_W-1:0]  p3_pin_function_enable_bit_i,
   input  wire logic [ppm_pkg::P3_W-1:0]  p3_pin_function_select_bit_i,
   input  wire logic [ppm_pkg::P3_W-1:0]  p3_pin_function_select_ext_bit_i,
   input  wire logic [ppm_pkg::P4_W-1:0]  p4_pin_function_enable_bit_i,
   // Peripheral outputs and pins
   input  wire logic                      hires_timer_out_a_i,
   input  wire logic                      hires_timer_out_b_i,
   input  wire logic                      serial0_tx_out_i,
   input  wire logic                      timer0_compare_out_a_i,
   input  wire logic                      alt_timer_out_a_i,
   input  wire logic                      alt_timer_out_b_i,
   input  wire logic                      timer1_compare_out_i,
   input  wire logic                      csi0_data_out_i,
   input  wire logic [ppm_pkg::P0_W-1:0]  p0_pin_i,
   // Design outputs
   input  wire logic [ppm_pkg::P0_W-1:0]  p0_pin_o,
   input  wire logic [ppm_pkg::P0_W-1:0]  p0_pin_oe_o,
   input  wire logic [ppm_pkg::P0_W-1:0]  p0_pullup_o,
   input  wire logic [ppm_pkg::P3_W-1:0]  p3_pin_o,
   input  wire logic [ppm_pkg::P3_W-1:0]  p3_pin_oe_o,
   input  wire logic [ppm_pkg::P4_W-1:0]  p4_pin_o,
   input  wire logic [ppm_pkg::P4_W-1:0]  p4_pin_oe_o,
   input  wire logic [3:0]                ext_irq_in_o
);
   logic [2:0] settle_reg;
   wire logic  rdy  = (settle_reg == 3'h6);
   wire logic  boff = idle_mode_i | stop_mode_i | bus_hold_i;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         settle_reg <= 3'h0;
      end else if (settle_reg != 3'h6) begin
         settle_reg <= settle_reg + 3'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   a_buf_off_oe:
      assert property (rdy && boff |=> ~|{p0_pin_oe_o, p3_pin_oe_o, p4_pin_oe_o})
      else $error("pin driven while buffers are off");
   a_hires_route:
      assert property (rdy && !boff && p0_pin_function_enable_bit_i[1:0] == 2'b11 |=>
         p0_pin_oe_o[1:0] == 2'b11 && p0_pin_o[1:0] == {$past(hires_timer_out_b_i),
         $past(hires_timer_out_a_i)}) else $error("hires timer not on pins");
   a_irq_follow:
      assert property (rdy && p0_pin_function_enable_bit_i[3] |=>
         ext_irq_in_o[0] == $past(p0_pin_i[3], 3)) else $error("irq input wrong");
   a_tx_route:
      assert property (rdy && !boff && p3_pin_function_enable_bit_i[0] |=>
         p3_pin_oe_o[0] && p3_pin_o[0] == $past(serial0_tx_out_i)) else $error("tx wrong");
   a_tmr_a_out:
      assert property (rdy && !boff && p3_pin_function_enable_bit_i[3] |=>
         p3_pin_oe_o[3] == $past(p3_pin_function_select_bit_i[3]) && (!p3_pin_oe_o[3] ||
         p3_pin_o[3] == ($past(p3_pin_function_select_ext_bit_i[3]) ? $past(alt_timer_out_a_i)
         : $past(timer0_compare_out_a_i)))) else $error("pin 3 timer select wrong");
   a_tmr_b_out:
      assert property (rdy && !boff && p3_pin_function_enable_bit_i[4] |=> p3_pin_oe_o[4] ==
         ($past(p3_pin_function_select_bit_i[4]) && $past(p3_pin_function_select_ext_bit_i[4]))
         && (!p3_pin_oe_o[4] || p3_pin_o[4] == $past(alt_timer_out_b_i)))
      else $error("pin 4 timer select wrong");
   a_tmr_one_out:
      assert property (rdy && !boff && p3_pin_function_enable_bit_i[5] |=> p3_pin_oe_o[5] ==
         $past(p3_pin_function_select_bit_i[5]) && (!p3_pin_oe_o[5] ||
         p3_pin_o[5] == $past(timer1_compare_out_i))) else $error("pin 5 timer wrong");
   a_csi_data_out:
      assert property (rdy && !boff && p4_pin_function_enable_bit_i[1] |=>
         p4_pin_oe_o[1] && p4_pin_o[1] == $past(csi0_data_out_i)) else $error("csi out wrong");
   a_port_drive:
      assert property (rdy && !boff |=> ((p0_pin_oe_o ^ ~$past(p0_pin_direction_bit_i)) &
         ~$past(p0_pin_function_enable_bit_i)) == '0 && ((p0_pin_o ^ $past(p0_latch_i)) &
         ~$past(p0_pin_function_enable_bit_i) & ~$past(p0_pin_direction_bit_i)) == '0)
      else $error("port mode drive wrong");
   a_pullup_input:
      assert property (rdy |=> p0_pullup_o == ($past(p0_pin_pullup_enable_bit_i) & ~p0_pin_oe_o))
      else $error("pull-up on a driven pin");
endmodule : ppm_port_pin_mux_chk
bind ppm_port_pin_mux ppm_port_pin_mux_chk u_ppm_port_pin_mux_chk (.*);
`default_nettype wire

// ==== verification/ppm_port_pin_mux_tb_top.sv ====
// Purpose: Directed bench for the port pin mux
// Assumes: Inputs change on the falling clock edge
// Notes:   Checks wait four cycles for pin paths to settle, two in t_buf_off and for the second hires timer check
`timescale 1ns/1ps
`default_nettype none
module ppm_port_pin_mux_tb_top;
   logic core_clk_i, rst_i, idle_mode_i, stop_mode_i, bus_hold_i;
   logic [ppm_pkg::P0_W-1:0] p0_latch_i, p0_pin_direction_bit_i, p0_pin_function_enable_bit_i;
   logic [ppm_pkg::P0_W-1:0] p0_pin_pullup_enable_bit_i, p0_pin_i, p0_pin_o, p0_pin_oe_o;
   logic [ppm_pkg::P0_W-1:0] p0_pullup_o, p0_read_o;
   logic [ppm_pkg::P3_W-1:0] p3_latch_i, p3_pin_direction_bit_i, p3_pin_function_enable_bit_i;
   logic [ppm_pkg::P3_W-1:0] p3_pin_function_select_bit_i, p3_pin_function_select_ext_bit_i;
   logic [ppm_pkg::P3_W-1:0] p3_pin_open_drain_bit_i, p3_pin_pullup_enable_bit_i, p3_pin_i;
   logic [ppm_pkg::P3_W-1:0] p3_pin_o, p3_pin_oe_o, p3_pullup_o, p3_read_o;
   logic [ppm_pkg::P4_W-1:0] p4_latch_i, p4_pin_direction_bit_i, p4_pin_function_enable_bit_i;
   logic [ppm_pkg::P4_W-1:0] p4_pin_open_drain_bit_i, p4_pin_pullup_enable_bit_i, p4_pin_i;
   logic [ppm_pkg::P4_W-1:0] p4_pin_o, p4_pin_oe_o, p4_pullup_o, p4_read_o;
   logic hires_timer_out_a_i, hires_timer_out_b_i, serial0_tx_out_i, timer0_compare_out_a_i;
   logic alt_timer_out_a_i, alt_timer_out_b_i, timer1_compare_out_i, two_wire_data_line_out_i;
   logic two_wire_clock_line_out_i, csi0_data_out_i, csi0_serial_clock_out_i;
   logic csi0_serial_clock_oe_i, nmi_in_o, serial0_rx_in_o, serial0_baud_clk_in_o;
   logic timer0_capture_in_a_o, alt_timer_in_a_o, timer0_capture_in_b_o, alt_timer_in_b_o;
   logic timer1_capture_in_o, two_wire_data_line_in_o, two_wire_clock_line_in_o;
   logic csi0_data_in_o, csi0_serial_clock_in_o;
   logic [3:0] ext_irq_in_o;
   int n_fail = 0;
   int comparisons = 0;
   ppm_port_pin_mux u_ppm_port_pin_mux (.*);
   ////////////////////////////////////////////////////////////////////////////
   task automatic step(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask : step
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic finish_test;
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_port;
      {p0_pin_direction_bit_i, p0_latch_i} = {7'h0f, 7'h35};
      {p0_pin_i, p0_pin_pullup_enable_bit_i} = {7'h4a, 7'h7f};
      step(4);
      chk(p0_pin_oe_o, 7'h70);
      chk(p0_pin_o & 7'h70, 7'h30);
      chk(p0_read_o, 7'h3a);
      chk(p0_pullup_o, 7'h0f);
      $display("port mode test done");
   endtask : t_port
   task automatic t_p0_alt;
      {p0_pin_function_enable_bit_i, p0_pin_direction_bit_i, p0_latch_i} = {7'h7f, 7'h00, 7'h7f};
      {hires_timer_out_a_i, hires_timer_out_b_i, p0_pin_i} = {2'b10, 7'h54};
      step(4);
      chk(p0_pin_oe_o, 7'h03);
      chk(p0_pin_o[1:0], 2'b01);
      chk({nmi_in_o, ext_irq_in_o}, 5'h1a);
      {hires_timer_out_a_i, hires_timer_out_b_i} = 2'b01;
      step(2);
      chk(p0_pin_o[1:0], 2'b10);
      $display("port 0 alternate test done");
   endtask : t_p0_alt
   task automatic t_buf_off;
      {p3_pin_function_enable_bit_i, p4_pin_function_enable_bit_i} = '0;
      {p3_pin_direction_bit_i, p4_pin_direction_bit_i} = '0;
      for (int k = 0; k < 3; k++) begin
         {idle_mode_i, stop_mode_i, bus_hold_i} = 3'b100 >> k;
         step(2);
         chk({p0_pin_oe_o, p3_pin_oe_o, p4_pin_oe_o}, 16'h0000);
         {idle_mode_i, stop_mode_i, bus_hold_i} = 3'b000;
         step(2);
         chk(p0_pin_oe_o, 7'h03);
      end
      $display("buffer off test done");
   endtask : t_buf_off
   task automatic t_p3;
      logic s;
      logic e;
      {p3_pin_function_enable_bit_i, p3_pin_i, serial0_tx_out_i} = {10'h03f, 10'h03e, 1'b1};
      {timer0_compare_out_a_i, alt_timer_out_a_i, alt_timer_out_b_i} = 3'b101;
      timer1_compare_out_i = 1'b1;
      for (int c = 0; c < 4; c++) begin
         s = c[0];
         e = c[1];
         p3_pin_function_select_bit_i = {4'h0, {3{s}}, 3'h0};
         p3_pin_function_select_ext_bit_i = {4'h0, {3{e}}, 3'h0};
         step(4);
         chk(p3_pin_oe_o[5:0], {s, e & s, s, 3'b001});
         chk(p3_pin_o[5:3] & p3_pin_oe_o[5:3], {s, e & s, s & !e});
         chk({timer0_capture_in_a_o, alt_timer_in_a_o, timer0_capture_in_b_o, alt_timer_in_b_o,
              timer1_capture_in_o}, {!s & !e, !s & e, !e, e & !s, !s});
         chk({p3_pin_o[0], serial0_rx_in_o, serial0_baud_clk_in_o}, 3'b111);
      end
      $display("port 3 timer and serial test done");
   endtask : t_p3
   task automatic t_two_wire;
      p3_latch_i = 10'h300;
      p3_pin_function_enable_bit_i = 10'h300;
      p3_pin_open_drain_bit_i = 10'h300;
      {two_wire_data_line_out_i, two_wire_clock_line_out_i, p3_pin_i} = {2'b01, 10'h140};
      {p3_pin_direction_bit_i, p3_pin_pullup_enable_bit_i} = {10'h0c0, 10'h3c0};
      step(4);
      chk({p3_pin_oe_o[9:8], p3_pin_o[8]}, 3'b010);
      chk({two_wire_clock_line_in_o, two_wire_data_line_in_o}, 2'b01);
      chk(p3_read_o, 10'h340);
      chk(p3_pullup_o, 10'h0c0);
      $display("two-wire test done");
   endtask : t_two_wire
   task automatic t_csi;
      {p4_pin_function_enable_bit_i, p4_pin_direction_bit_i, p4_pin_i} = {3'h7, 3'h7, 3'h1};
      {csi0_data_out_i, csi0_serial_clock_out_i, csi0_serial_clock_oe_i} = 3'b111;
      for (int k = 0; k < 2; k++) begin
         p4_pin_open_drain_bit_i = k[0] ? 3'h7 : 3'h0;
         step(4);
         chk({p4_pin_oe_o, p4_pin_o[2:1], csi0_data_in_o}, 6'h37);
      end
      {csi0_serial_clock_oe_i, p4_pin_i} = {1'b0, 3'h4};
      p4_pin_pullup_enable_bit_i = 3'h7;
      step(4);
      chk({p4_pin_oe_o[2], csi0_serial_clock_in_o}, 2'b01);
      chk(p4_read_o, 3'h4);
      chk(p4_pullup_o, 3'h5);
      $display("clocked serial test done");
   endtask : t_csi
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end
   initial begin
      repeat (5000) @(posedge core_clk_i);
      n_fail++;
      finish_test();
   end
   initial begin
      {idle_mode_i, stop_mode_i, bus_hold_i, p0_latch_i, p0_pin_direction_bit_i,
       p0_pin_function_enable_bit_i, p0_pin_pullup_enable_bit_i, p0_pin_i} = '0;
      {p3_latch_i, p3_pin_direction_bit_i, p3_pin_function_enable_bit_i,
       p3_pin_function_select_bit_i, p3_pin_function_select_ext_bit_i,
       p3_pin_open_drain_bit_i, p3_pin_pullup_enable_bit_i, p3_pin_i} = '0;
      {p4_latch_i, p4_pin_direction_bit_i, p4_pin_function_enable_bit_i,
       p4_pin_open_drain_bit_i, p4_pin_pullup_enable_bit_i, p4_pin_i} = '0;
      {hires_timer_out_a_i, hires_timer_out_b_i, serial0_tx_out_i, timer0_compare_out_a_i,
       alt_timer_out_a_i, alt_timer_out_b_i, timer1_compare_out_i, two_wire_data_line_out_i,
       two_wire_clock_line_out_i, csi0_data_out_i, csi0_serial_clock_out_i,
       csi0_serial_clock_oe_i} = '0;
      rst_i = 1'b1;
      step(4);
      chk({p0_pin_oe_o, p3_pin_oe_o, p4_pin_oe_o}, 16'h0000);
      rst_i = 1'b0;
      step(2);
      t_port();
      t_p0_alt();
      t_buf_off();
      t_p3();
      t_two_wire();
      t_csi();
      finish_test();
   end
endmodule : ppm_port_pin_mux_tb_top
`default_nettype wire
